// file: design/dpsem_host.sv
`timescale 1ns/1ps
// Overview of operation
// - memory access uses chip select, strobe, enable
// - never assert both selects together
// - flag chosen by three lowest address bits
// - same-address access needs arbitration
// - wait contention delay before sampling read
module dpsem_host
  import dpsem_pkg::*;
#(
  parameter int ACC_CYC = dpsem_pkg::ACCESS_CYC
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // command port
  input wire logic REQ_I,
  input wire dpsem_pkg::dpsem_cmd_t CMD_I,
  input wire logic [dpsem_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [dpsem_pkg::DATA_W-1:0] WDATA_I,
  output logic READY_O,
  output logic DONE_O,
  output logic [dpsem_pkg::DATA_W-1:0] RDATA_O,
  output logic OWNED_O,
  // device port pins
  output logic CHIP_SEL_N_O,
  output logic RW_N_O,
  output logic OUT_EN_N_O,
  output logic SEMAPHORE_SELECT_N_O,
  output logic [dpsem_pkg::ADDR_W-1:0] ADDR_O,
  input wire logic [dpsem_pkg::DATA_W-1:0] DATA_I,
  output logic [dpsem_pkg::DATA_W-1:0] DATA_O,
  output logic DATA_OE_N_O,
  input wire logic BUSY_N_I
);
  import dpsem_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef enum {DPSEM_IDLE, DPSEM_SETUP, DPSEM_STROBE, DPSEM_WAIT, DPSEM_END} dpsem_state_t;

  dpsem_state_t state_r; // sequencer state
  dpsem_cmd_t cmd_r; // latched command
  logic [CNT_W-1:0] cnt_r; // cycle counter
  logic [DATA_W-1:0] data_s; // synchronised data bus
  logic [0:0] busy_s; // synchronised busy pin

  // data bus and busy pin pass two flip-flops
  dpsem_sync #(.WIDTH(DATA_W)) u_sync_data (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .async_i(DATA_I),
    .sync_o(data_s)
  );
  dpsem_sync #(.WIDTH(1)) u_sync_busy (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .async_i(BUSY_N_I),
    .sync_o(busy_s)
  );

  // true when the given command is a semaphore access
  function automatic logic is_sem(input dpsem_cmd_t c);
    return (c == DPSEM_SEM_RD) || (c == DPSEM_SEM_WR);
  endfunction

  // true when the given command writes
  function automatic logic is_wr(input dpsem_cmd_t c);
    return (c == DPSEM_MEM_WR) || (c == DPSEM_SEM_WR);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= DPSEM_IDLE;
      cmd_r <= DPSEM_MEM_RD;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        DPSEM_IDLE: begin
          // accept a command
          if (REQ_I) begin
            cmd_r <= CMD_I;
            state_r <= DPSEM_SETUP;
          end
        end
        DPSEM_SETUP: begin
          // address settles one cycle before strobes
          cnt_r <= is_wr(cmd_r) ? CNT_W'(STROBE_CYC) : CNT_W'(ACC_CYC);
          state_r <= is_wr(cmd_r) ? DPSEM_STROBE : DPSEM_WAIT;
        end
        DPSEM_STROBE: begin
          // write pulse, extended while busy is low on a memory write
          if (cnt_r > CNT_W'(1)) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else if (is_sem(cmd_r) || busy_s[0] == PIN_HI) begin
            state_r <= DPSEM_END;
          end
        end
        DPSEM_WAIT: begin
          // read data settle plus two sync stages, held off by busy on a memory read
          if (cnt_r > CNT_W'(0)) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else if (is_sem(cmd_r) || busy_s[0] == PIN_HI) begin
            state_r <= DPSEM_END;
          end
        end
        DPSEM_END: begin
          // controls back to idle levels
          state_r <= DPSEM_IDLE;
        end
        default: begin
          state_r <= DPSEM_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // device control pins; selects are mutually exclusive
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CHIP_SEL_N_O <= PIN_HI;
      SEMAPHORE_SELECT_N_O <= PIN_HI;
      RW_N_O <= PIN_HI;
      OUT_EN_N_O <= PIN_HI;
    end else begin
      if (state_r == DPSEM_IDLE && REQ_I) begin
        // memory uses chip select, semaphore uses its own select
        CHIP_SEL_N_O <= is_sem(CMD_I) ? PIN_HI : PIN_LO;
        SEMAPHORE_SELECT_N_O <= is_sem(CMD_I) ? PIN_LO : PIN_HI;
      end else if (state_r == DPSEM_SETUP) begin
        // strobe low for writes, output enable low for reads
        RW_N_O <= is_wr(cmd_r) ? PIN_LO : PIN_HI;
        OUT_EN_N_O <= is_wr(cmd_r) ? PIN_HI : PIN_LO;
      end else if (state_r == DPSEM_STROBE && cnt_r <= CNT_W'(1) &&
                   (is_sem(cmd_r) || busy_s[0] == PIN_HI)) begin
        // end of write pulse
        RW_N_O <= PIN_HI;
      end else if (state_r == DPSEM_END) begin
        // release everything; port drops to standby
        CHIP_SEL_N_O <= PIN_HI;
        SEMAPHORE_SELECT_N_O <= PIN_HI;
        RW_N_O <= PIN_HI;
        OUT_EN_N_O <= PIN_HI;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address and write data
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ADDR_O <= '0;
      DATA_O <= '0;
      DATA_OE_N_O <= PIN_HI;
    end else begin
      if (state_r == DPSEM_IDLE && REQ_I) begin
        // semaphore accesses carry only the three flag bits
        ADDR_O <= is_sem(CMD_I) ? ADDR_W'(ADDR_I[SEM_SEL_W-1:0]) : ADDR_I;
        // semaphore request writes bit zero; upper lines follow it
        DATA_O <= is_sem(CMD_I) ? {DATA_W{WDATA_I[0]}} : WDATA_I;
        DATA_OE_N_O <= is_wr(CMD_I) ? PIN_LO : PIN_HI;
      end else if (state_r == DPSEM_END) begin
        DATA_OE_N_O <= PIN_HI;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer to the command port
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      READY_O <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= '0;
      OWNED_O <= 1'b0;
    end else begin
      READY_O <= (state_r == DPSEM_IDLE && !REQ_I) || (state_r == DPSEM_END);
      DONE_O <= (state_r == DPSEM_END);
      if (state_r == DPSEM_END && !is_wr(cmd_r)) begin
        RDATA_O <= data_s;
        // flag read low means this port holds the token
        OWNED_O <= (cmd_r == DPSEM_SEM_RD) && (data_s[0] == PIN_LO);
      end
    end
  end
endmodule

// file: common/dpsem_pkg.sv
package dpsem_pkg;
  // array geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int SEM_SEL_W = 3;
  localparam int SEM_COUNT = 8;
  // pin levels on the device side
  localparam logic PIN_HI = 1'b1;
  localparam logic PIN_LO = 1'b0;
  // clock and strobe timing
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // settle time before sampling read data, covers contention_data_delay
  localparam int ACCESS_NS = 70;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // write strobe low time
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // command codes
  typedef enum logic [1:0] {
    DPSEM_MEM_RD,
    DPSEM_MEM_WR,
    DPSEM_SEM_RD,
    DPSEM_SEM_WR
  } dpsem_cmd_t;
endpackage

// file: design/dpsem_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for a bus of pin inputs
module dpsem_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by second stage

  // two stage capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// file: testbench/dpsem_host_assertions.sv
`timescale 1ns/1ps
// pin checks on the host side of the memory port
module dpsem_host_assertions (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic DONE_O,
  input wire logic CHIP_SEL_N_O,
  input wire logic RW_N_O,
  input wire logic OUT_EN_N_O,
  input wire logic SEMAPHORE_SELECT_N_O,
  input wire logic [13:0] ADDR_O,
  input wire logic [7:0] DATA_O,
  input wire logic DATA_OE_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  excl_sel_a: assert property (CHIP_SEL_N_O || SEMAPHORE_SELECT_N_O)
    else $error("both selects low");
  no_fight_a: assert property (!DATA_OE_N_O |-> OUT_EN_N_O)
    else $error("bus driven by both sides");
  wr_data_a: assert property (!RW_N_O |-> !DATA_OE_N_O)
    else $error("strobe without data");
  sem_addr_a: assert property (!SEMAPHORE_SELECT_N_O |-> ADDR_O[13:3] == 0)
    else $error("semaphore address high bits");
  sem_data_a: assert property (!(SEMAPHORE_SELECT_N_O | DATA_OE_N_O) |->
    DATA_O == {8{DATA_O[0]}})
    else $error("semaphore data lines differ");
  one_done_a: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");
  short_wr_a: assert property ($fell(RW_N_O) |=> RW_N_O)
    else $error("strobe length");
  wr_hold_a: assert property (!RW_N_O |-> $stable(ADDR_O) && $stable(DATA_O))
    else $error("address or data moved in strobe");
endmodule
bind dpsem_host dpsem_host_assertions chk (.CLK_I(CLK_I), .RST_I(RST_I), .DONE_O(DONE_O),
  .CHIP_SEL_N_O(CHIP_SEL_N_O), .RW_N_O(RW_N_O), .OUT_EN_N_O(OUT_EN_N_O), .ADDR_O(ADDR_O),
  .SEMAPHORE_SELECT_N_O(SEMAPHORE_SELECT_N_O), .DATA_O(DATA_O), .DATA_OE_N_O(DATA_OE_N_O));

// file: testbench/dpsem_dev.sv
`timescale 1ns/1ps
// behavioural dual-port memory, one port facing the host
module dpsem_dev (
  input wire logic cs_n_i,
  input wire logic rw_n_i,
  input wire logic oe_n_i,
  input wire logic sem_n_i,
  input wire logic [13:0] addr_i,
  input wire logic [7:0] host_i,
  input wire logic host_oe_n_i,
  input wire logic contend_i,
  output logic [7:0] bus_o,
  output logic busy_n_o
);
  logic [7:0] mem [16384];
  logic [7:0] flag = 8'hFF; // eight free tokens
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  logic drive;
  // master drives busy low while the opposite port holds the contended word
  assign busy_n_o = !contend_i;
  // writes land at the end of the strobe
  always @(posedge rw_n_i) begin
    if (!cs_n_i && sem_n_i) mem[addr_i] <= host_i;
    if (cs_n_i && !sem_n_i) flag[addr_i[2:0]] <= host_i[0];
  end
  // read drive; a floated bus shows the inverse of its last value
  assign drive = rw_n_i && !oe_n_i && (cs_n_i != sem_n_i);
  assign rd = cs_n_i ? {8{flag[addr_i[2:0]]}} : mem[addr_i];
  always @(rd or drive) if (drive) last = rd;
  assign bus_o = !host_oe_n_i ? host_i : (drive ? rd : ~last);
endmodule

// file: testbench/dpsem_host_tb.sv
`timescale 1ns/1ps
// self-checking bench for the host controller
module dpsem_host_tb;
  import dpsem_pkg::*;
  logic clk = 0, rst = 1, req = 0, ready, done, owned, cs_n, rw_n, oe_n, sem_n, doe_n, busy_n;
  dpsem_cmd_t cmd = DPSEM_MEM_RD;
  logic [13:0] addr = 0, pin_a, a;
  logic [7:0] wdata = 0, rdata, din, dout, d, semaphore_select_n [8];
  logic [7:0] mem [int];
  logic [31:0] seed = 94326;
  logic contend = 0; // opposite port holding the word under test
  int fail_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  dpsem_host #(.ACC_CYC(1)) uut (.CLK_I(clk), .RST_I(rst), .REQ_I(req), .CMD_I(cmd),
    .ADDR_I(addr), .WDATA_I(wdata), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
    .OWNED_O(owned), .CHIP_SEL_N_O(cs_n), .RW_N_O(rw_n), .OUT_EN_N_O(oe_n),
    .SEMAPHORE_SELECT_N_O(sem_n), .ADDR_O(pin_a), .DATA_I(din), .DATA_O(dout),
    .DATA_OE_N_O(doe_n), .BUSY_N_I(busy_n));
  dpsem_dev dev (.cs_n_i(cs_n), .rw_n_i(rw_n), .oe_n_i(oe_n), .sem_n_i(sem_n), .addr_i(pin_a),
    .host_i(dout), .host_oe_n_i(doe_n), .contend_i(contend), .bus_o(din), .busy_n_o(busy_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [8:0] e, logic [8:0] g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // one transfer: request at a falling edge, wait for done
  task automatic op(dpsem_cmd_t c, logic [13:0] ad, logic [7:0] wd);
    int n;
    n = 0;
    while (ready !== 1'b1) @(negedge clk);
    cmd = c;
    addr = ad;
    wdata = wd;
    req = 1;
    @(negedge clk);
    req = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) check("done", 1, 0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 20; i++) begin
      a = i == 0 ? 14'h0000 : (i == 1 ? 14'h3FFF : 14'(rnd()));
      d = 8'(rnd());
      op(DPSEM_MEM_WR, a, d);
      mem[a] = d;
    end
    for (int i = 0; i < 16; i++) begin
      a = {11'(rnd()), 3'(i)};
      d = 8'(rnd());
      op(DPSEM_SEM_WR, a, d);
      semaphore_select_n[i % 8] = {8{d[0]}};
    end
    foreach (mem[k]) begin
      op(DPSEM_MEM_RD, 14'(k), 8'h00);
      check("memory read", {1'b0, mem[k]}, {1'b0, rdata});
    end
    $display("test memory done");
    // read held off while the opposite port keeps busy low
    contend = 1;
    fork
      begin
        op(DPSEM_MEM_RD, 14'h3FFF, 8'h00);
        check("read held by busy", 9'h000, {8'h00, contend});
        check("contended read", {1'b0, mem[14'h3FFF]}, {1'b0, rdata});
      end
      begin
        repeat (20) @(negedge clk);
        contend = 0;
      end
    join
    $display("test contention done");
    for (int i = 0; i < 8; i++) begin
      op(DPSEM_SEM_RD, {11'(rnd()), 3'(i)}, 8'h00);
      check("flag read", {~semaphore_select_n[i][0], semaphore_select_n[i]}, {owned, rdata});
    end
    $display("test semaphore done");
    stop_test();
  end
  initial begin
    #(25 * 5000);
    fail_count++;
    stop_test();
  end
endmodule
